// >>> src/sfc_map.svh
// Constants of the serial flash command block: opcodes, status bit
// positions, byte positions in a frame, sizes and timing.
// Included by the design files; holds definitions only.
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH

// Opcodes, shifted in most significant bit first
`define SFC_OP_SET_LATCH   8'h06
`define SFC_OP_CLR_LATCH   8'h04
`define SFC_OP_IDENT       8'h9f
`define SFC_OP_STATUS      8'h05
`define SFC_OP_READ        8'h03
`define SFC_OP_FAST_READ   8'h0b
`define SFC_OP_REWRITE     8'h0a

// Status byte layout and reset value
`define SFC_ST_BUSY_BIT    0
`define SFC_ST_LATCH_BIT   1
`define SFC_ST_RESET       8'h00

// Completed-byte counts inside a frame
`define SFC_BYTE_OPCODE    5'h01
`define SFC_BYTE_ADDR_LAST 5'h03
`define SFC_BYTE_DUMMY     5'h04
`define SFC_BYTE_RW_MIN    5'h05
`define SFC_BYTE_SAT       5'h1f
`define SFC_ID_LAST        5'h13

// Identification trailer
`define SFC_CFD_LEN        8'h10

// Array geometry
`define SFC_PAGE_LAST      8'hff
`define SFC_MEM_AW         11
`define SFC_MEM_BYTES      2048
`define SFC_PROT_TOP       8'h00
`define SFC_ERASED         8'hff

// Timing
`define SFC_CLK_NS         50
`define SFC_CYCLE_NS       1000000

`endif

// >>> src/sfc_pkg.sv
// Types shared by the serial flash command block.
// Assumes the constants header is included where numbers are needed.
package sfc_pkg;
  // Self-timed rewrite sequencer
  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_COPY,
    CYC_TIMER
  } sfc_cyc_t;
  typedef logic [7:0]  sfc_byte_t;
  typedef logic [23:0] sfc_addr_t;
endpackage

// >>> src/sfc_sync.sv
// Two-flop level synchroniser into the system clock domain.
// Assumes inputs are slow levels or toggles from pins or link logic.
`timescale 1ns/1ps
`default_nettype none
module sfc_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta_r;

  ////////////////////////////////////////////////////////////////////
  // Both stages; metastability settles in the first
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> src/sfc_top.sv
// Serial flash command handling as seen from inside the memory.
// Assumes the master keeps the serial clock still while deselected
// and that the array below is a small alias of the full address map.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_map.svh"

// How it works
// - Opcode byte first; latch set, clear, identify
// - Status, normal read, fast read opcodes
// - Rewrite: opcode, three address, 1-256 data
// - Latch and rewrite need whole bytes
// - Set-latch command sets write latch flag
// - No modifying command without write latch
// - Clear-latch command clears write latch flag
// - Latch cleared at reset and when the page copy ends
// - Identify: maker, type, capacity, length, custom
// - Length byte 10h, custom bytes read-only
// - Identify ignored while a cycle runs
// - Output changes on falling edges
// - Status answered anytime, repeats while clocked
// - Busy flag set only during cycles
// - Normal read: opcode, address, data out
// - Read address increments, wraps to zero
// - Normal read rejected while busy
// - Fast read adds one dummy byte
// - Fast read rejected while busy
// - Rewrite erases page, keeps unsent bytes
// - Rewrite data wraps inside the page
// - Last 256 bytes kept for the page
// - Rewrite needs whole last data byte
// - Select rise starts cycle, busy held
// - Protected or busy-time rewrite not executed
module sfc_top
  import sfc_pkg::*;
#(
  parameter int unsigned CYCLE_NS   = `SFC_CYCLE_NS,
  parameter sfc_byte_t   MAKER_CODE = 8'h5a, // Arbitrary value
  parameter sfc_byte_t   TYPE_CODE  = 8'h3c, // Arbitrary value
  parameter sfc_byte_t   CAP_CODE   = 8'h0e, // Arbitrary value
  parameter logic [127:0] CFD_DATA  = '0
) (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic sclk_in,
  input  wire logic sel_n_in,
  input  wire logic serial_in_pin_in,
  input  wire logic protect_n_in,
  output logic      serial_out_pin_out,
  output logic      serial_out_oe_n_out,
  output logic      busy_flag_out,
  output logic      write_latch_flag_out
);
  // Self-timed cycle length, rounded up to whole clocks
  localparam int unsigned CYCLE_CLKS =
    (CYCLE_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS;

  ////////////////////////////////////////////////////////////////////
  // Shared helpers

  // Status byte assembly
  function automatic sfc_byte_t status_of(input logic busy,
                                          input logic write_latch_flag);
    sfc_byte_t s;
    s = `SFC_ST_RESET;
    s[`SFC_ST_BUSY_BIT]  = busy;
    s[`SFC_ST_LATCH_BIT] = write_latch_flag;
    return s;
  endfunction

  // Identification byte by position after the opcode
  function automatic sfc_byte_t id_byte(input logic [4:0] i);
    sfc_byte_t  b;
    logic [4:0] ci;
    b  = 8'h00;
    ci = `SFC_ID_LAST - i;
    case (i)
      5'h00:   b = MAKER_CODE;
      5'h01:   b = TYPE_CODE;
      5'h02:   b = CAP_CODE;
      5'h03:   b = `SFC_CFD_LEN;
      default:
        if (i <= `SFC_ID_LAST)
          b = CFD_DATA[{ci[3:0], 3'h0} +: 8];
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Storage

  // Array, written only by the system clock sequencer
  sfc_byte_t mem [`SFC_MEM_BYTES];
  // Page data gathered by the link, read while busy freezes its capture
  sfc_byte_t pbuf [256];

  ////////////////////////////////////////////////////////////////////
  // Link domain: runs on the serial clock while selected

  logic         link_rst;   // Select high or system reset
  logic         live_r;     // Low until the frame's first edge
  logic [2:0]   bit_r;      // Bits taken mod eight
  logic [4:0]   byte_r;     // Whole bytes taken, saturating
  sfc_byte_t    rx_r;       // Input shifter
  sfc_byte_t    rx_nxt;     // Shifter with the current bit
  sfc_byte_t    opcode_r;   // Frame opcode
  sfc_addr_t    addr_r;     // Address as shifted in
  sfc_addr_t    full_addr;  // Address including current byte
  sfc_addr_t    rd_addr_r;  // Next read address
  sfc_addr_t    rd_src;     // Address of the byte being fetched
  sfc_byte_t    op_now;     // Opcode valid at this edge
  logic [7:0]   wptr_r;     // Page offset of next data byte
  logic [255:0] vmask_r;    // Offsets written this frame
  logic         tog_r;      // Flips once per frame
  logic [1:0]   bw1_r;      // Busy/latch, first sync stage
  logic [1:0]   bw2_r;      // Busy/latch, second sync stage
  logic         byte_done;  // A byte completes on this edge
  logic         rd_go;      // Fetch an array byte
  sfc_byte_t    tx_r;       // Next byte to shift out
  sfc_byte_t    out_sr_r;   // Output shifter, falling edge
  logic         oe_n_r;     // Output enable, low drives

  assign link_rst  = rst_in | sel_n_in;
  assign rx_nxt    = {rx_r[6:0], serial_in_pin_in};
  assign byte_done = live_r && (bit_r == 3'h7);
  assign full_addr = {addr_r[15:0], rx_nxt};
  assign op_now    = (byte_r == 5'h00) ? rx_nxt : opcode_r;
  assign rd_src    = (byte_r == `SFC_BYTE_ADDR_LAST) ? full_addr
                                                     : rd_addr_r;
  // Reads start after the address or the dummy byte; none while busy
  assign rd_go = byte_done && !bw2_r[0] &&
    ((op_now == `SFC_OP_READ &&
      byte_r >= `SFC_BYTE_ADDR_LAST) ||
     (op_now == `SFC_OP_FAST_READ &&
      byte_r >= `SFC_BYTE_DUMMY));

  // Frame marker, cleared whenever select is high
  always_ff @(posedge sclk_in or posedge link_rst)
  begin
    if (link_rst)
      live_r <= 1'b0;
    else
      live_r <= 1'b1;
  end

  // Bit and byte counters; kept after select rises for the verdict
  always_ff @(posedge sclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_r   <= 8'h00;
      bit_r  <= 3'h0;
      byte_r <= 5'h00;
      tog_r  <= 1'b0;
    end
    else
    begin
      rx_r  <= rx_nxt;
      bit_r <= live_r ? bit_r + 3'h1 : 3'h1;
      if (!live_r)
      begin
        // Fresh frame announces itself to the other domain
        byte_r <= 5'h00;
        tog_r  <= ~tog_r;
      end
      else if (byte_done && byte_r != `SFC_BYTE_SAT)
        byte_r <= byte_r + 5'h01;
    end
  end

  // Opcode and address capture, most significant bit first
  always_ff @(posedge sclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      opcode_r <= 8'h00;
      addr_r   <= 24'h000000;
    end
    else if (byte_done)
    begin
      if (byte_r == 5'h00)
        opcode_r <= rx_nxt;
      else if (byte_r <= `SFC_BYTE_ADDR_LAST)
        addr_r <= full_addr;
    end
  end

  // Read address: loaded at the address, stepped per data byte
  always_ff @(posedge sclk_in or posedge rst_in)
  begin
    if (rst_in)
      rd_addr_r <= 24'h000000;
    else if (rd_go)
      rd_addr_r <= rd_src + 24'h000001;
    else if (byte_done && byte_r == `SFC_BYTE_ADDR_LAST)
      rd_addr_r <= full_addr;
  end

  // Page data capture; frozen while a cycle uses it
  always_ff @(posedge sclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wptr_r  <= 8'h00;
      vmask_r <= '0;
    end
    else if (byte_done && !bw2_r[0])
    begin
      if (byte_r == `SFC_BYTE_ADDR_LAST)
      begin
        wptr_r  <= rx_nxt;
        vmask_r <= '0;
      end
      else if (byte_r > `SFC_BYTE_ADDR_LAST &&
               opcode_r == `SFC_OP_REWRITE)
      begin
        vmask_r[wptr_r] <= 1'b1;
        // Offset wraps inside the page; late bytes overwrite
        wptr_r <= wptr_r + 8'h01;
      end
    end
  end

  // Page buffer has no reset; the mask says what is valid
  always_ff @(posedge sclk_in)
  begin
    if (byte_done && !bw2_r[0] && byte_r > `SFC_BYTE_ADDR_LAST &&
        opcode_r == `SFC_OP_REWRITE)
      pbuf[wptr_r] <= rx_nxt;
  end

  // Busy and latch into the link; the opcode byte gives them time
  always_ff @(posedge sclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bw1_r <= 2'h0;
      bw2_r <= 2'h0;
    end
    else
    begin
      bw1_r <= {write_latch_flag_out, busy_flag_out};
      bw2_r <= bw1_r;
    end
  end

  // Next output byte, chosen as each byte completes
  always_ff @(posedge sclk_in or posedge rst_in)
  begin
    if (rst_in)
      tx_r <= 8'h00;
    else if (byte_done)
    begin
      if (op_now == `SFC_OP_STATUS)
        tx_r <= status_of(bw2_r[0], bw2_r[1]);
      else if (op_now == `SFC_OP_IDENT && !bw2_r[0])
        tx_r <= id_byte(byte_r);
      else if (rd_go)
        tx_r <= mem[rd_src[`SFC_MEM_AW-1:0]];
      else
        tx_r <= 8'h00;
    end
  end

  // Output shifter on the falling edge; ends with the frame
  always_ff @(negedge sclk_in or posedge link_rst)
  begin
    if (link_rst)
      out_sr_r <= 8'h00;
    else if (live_r && bit_r == 3'h0)
      out_sr_r <= tx_r;
    else
      out_sr_r <= {out_sr_r[6:0], 1'b0};
  end

  // Pin driven from the first falling edge of a frame
  always_ff @(negedge sclk_in or posedge link_rst)
  begin
    if (link_rst)
      oe_n_r <= 1'b1;
    else
      oe_n_r <= 1'b0;
  end

  assign serial_out_pin_out  = out_sr_r[7];
  assign serial_out_oe_n_out = oe_n_r;

  ////////////////////////////////////////////////////////////////////
  // System domain: frame verdicts and the self-timed cycle

  logic [2:0] sync_s;     // Toggle, protect, select
  logic       sel_q_r;    // Select as seen last clock
  logic       tog_seen_r; // Frame toggle already handled
  logic       end_ev;     // A clocked frame just ended
  logic       whole;      // Frame ended on a byte boundary
  logic       prot;       // Target page is protected
  logic       set_ok;     // Valid set-latch frame
  logic       clr_ok;     // Valid clear-latch frame
  logic       rw_end;     // Well-formed rewrite frame ended
  logic       rw_ok;      // Rewrite accepted
  logic       wel_r;      // Write latch flag
  logic       busy_r;     // Busy flag
  sfc_cyc_t   cyc_r;      // Sequencer state
  logic [15:0] page_r;    // Page under rewrite
  logic [7:0] idx_r;      // Copy offset
  logic [31:0] tmr_r;     // Cycle timer

  sfc_sync #(
    .WIDTH (3)
  ) u_sync (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .async_in ({tog_r, protect_n_in, sel_n_in}),
    .sync_out (sync_s)
  );

  // Link registers are still once select is high, so read directly
  assign end_ev = sync_s[0] && !sel_q_r && (sync_s[2] != tog_seen_r);
  assign whole  = (bit_r == 3'h0);
  assign prot   = !sync_s[1] && (addr_r[23:16] == `SFC_PROT_TOP);
  assign set_ok = end_ev && whole && byte_r == `SFC_BYTE_OPCODE &&
                  opcode_r == `SFC_OP_SET_LATCH;
  assign clr_ok = end_ev && whole && byte_r == `SFC_BYTE_OPCODE &&
                  opcode_r == `SFC_OP_CLR_LATCH;
  assign rw_end = end_ev && whole && byte_r >= `SFC_BYTE_RW_MIN &&
                  opcode_r == `SFC_OP_REWRITE;
  assign rw_ok  = rw_end && wel_r && !busy_r && !prot;

  // Select edge and frame bookkeeping
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sel_q_r    <= 1'b1;
      tog_seen_r <= 1'b0;
    end
    else
    begin
      sel_q_r <= sync_s[0];
      if (end_ev)
        tog_seen_r <= sync_s[2];
    end
  end

  // Write latch; cleared before the cycle ends so polling sees it
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      wel_r <= 1'b0;
    else if (cyc_r == CYC_COPY && idx_r == `SFC_PAGE_LAST)
      wel_r <= 1'b0;
    else if (set_ok)
      wel_r <= 1'b1;
    else if (clr_ok)
      wel_r <= 1'b0;
  end

  // Sequencer: merge the page, then wait out the cycle time
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cyc_r  <= CYC_IDLE;
      busy_r <= 1'b0;
      page_r <= 16'h0000;
      idx_r  <= 8'h00;
      tmr_r  <= 32'h0;
    end
    else
    begin
      case (cyc_r)
        CYC_IDLE:
          if (rw_ok)
          begin
            cyc_r  <= CYC_COPY;
            busy_r <= 1'b1;
            page_r <= addr_r[23:8];
            idx_r  <= 8'h00;
          end
        CYC_COPY:
        begin
          idx_r <= idx_r + 8'h01;
          if (idx_r == `SFC_PAGE_LAST)
          begin
            cyc_r <= CYC_TIMER;
            tmr_r <= 32'h0;
          end
        end
        CYC_TIMER:
          // Busy clears by itself once the time has run
          if (tmr_r >= 32'(CYCLE_CLKS - 1))
          begin
            cyc_r  <= CYC_IDLE;
            busy_r <= 1'b0;
          end
          else
            tmr_r <= tmr_r + 32'h1;
        default:
        begin
          cyc_r  <= CYC_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // Erase-then-program per byte: sent bytes replace, others stay
  always_ff @(posedge mclk_in)
  begin
    if (cyc_r == CYC_COPY)
      mem[{page_r[`SFC_MEM_AW-9:0], idx_r}] <=
        vmask_r[idx_r] ? pbuf[idx_r]
                       : mem[{page_r[`SFC_MEM_AW-9:0], idx_r}];
  end

  assign busy_flag_out        = busy_r;
  assign write_latch_flag_out = wel_r;

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  property p_latch_set;
    set_ok && !(cyc_r == CYC_COPY && idx_r == `SFC_PAGE_LAST) |=> wel_r;
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("latch not set by set command");

  property p_latch_clr;
    clr_ok && !(cyc_r == CYC_COPY) |=> !wel_r;
  endproperty
  a_latch_clr: assert property (p_latch_clr)
    else $error("latch not cleared by clear command");

  property p_ragged;
    end_ev && !whole && !(cyc_r == CYC_COPY) |=> wel_r == $past(wel_r);
  endproperty
  a_ragged: assert property (p_ragged)
    else $error("partial byte frame changed the latch");

  property p_start;
    rw_ok |=> (busy_r && cyc_r == CYC_COPY) [*8];
  endproperty
  a_start: assert property (p_start)
    else $error("rewrite cycle did not start");

  property p_need_latch;
    rw_end && !wel_r && !busy_r |=> !busy_r;
  endproperty
  a_need_latch: assert property (p_need_latch)
    else $error("rewrite ran without latch");

  property p_protect;
    rw_end && prot && !busy_r |=> !busy_r;
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected page rewritten");

  property p_busy_reject;
    rw_end && busy_r |=> $stable(page_r);
  endproperty
  a_busy_reject: assert property (p_busy_reject)
    else $error("rewrite during cycle disturbed it");

  property p_busy_cycle;
    cyc_r != CYC_IDLE |-> busy_r;
  endproperty
  a_busy_cycle: assert property (p_busy_cycle)
    else $error("busy low during a cycle");

  property p_latch_drop;
    cyc_r == CYC_COPY && idx_r == `SFC_PAGE_LAST |=>
      !wel_r && cyc_r == CYC_TIMER;
  endproperty
  a_latch_drop: assert property (p_latch_drop)
    else $error("latch kept past cycle");

  c_set:     cover property (set_ok);
  c_rewrite: cover property (rw_ok);
  c_done:    cover property ($fell(busy_r));
  c_ragged:  cover property (end_ev && !whole);
endmodule
`default_nettype wire

// >>> test/sfc_master_model.sv
// Bus master model for the serial flash command block.
// Assumes the bench loads tx before run and reads rx after it.
`timescale 1ns/1ps
`default_nettype none
module sfc_master_model
  import sfc_pkg::*;
(
  output logic      sel_n_out,
  output logic      sclk_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  localparam realtime HALF = 62.5; // 125 ns link clock
  sfc_byte_t tx[$];                // Bytes to shift out
  sfc_byte_t rx[$];                // Bytes captured
  ////////////////////////////////////////////////////////////////////
  // Idle: deselected, clock low (mode 0)
  initial
  begin
    sel_n_out = 1'b1;
    sclk_out  = 1'b0;
    mosi_out  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////
  // One frame of nbits clocks; clock stands still outside it
  task automatic run(input int nbits);
    sfc_byte_t sh;
    rx.delete();
    sh = 8'h00;
    sel_n_out = 1'b0;
    #(HALF);
    for (int i = 0; i < nbits; i++)
    begin
      // Past the loaded bytes the line toggles: don't-care bits
      mosi_out = (i / 8 < tx.size()) ? tx[i / 8][7 - i % 8] : i[0];
      #(HALF);
      sclk_out = 1'b1;
      sh = {sh[6:0], miso_in};
      if (i % 8 == 7)
        rx.push_back(sh);
      #(HALF);
      sclk_out = 1'b0;
    end
    #(HALF);
    // Select rises only where the bench asked: whole or broken byte
    sel_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #(300); // Deselect gap above 200 ns
  endtask
endmodule
`default_nettype wire

// >>> test/serial_flash_cmd_read_write_bench.sv
// Self-checking bench for the serial flash command block.
// Assumes the master model in sfc_master_model drives the link.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_cmd_read_write_bench
  import sfc_pkg::*;
;
  localparam sfc_byte_t MK = 8'h6b; // Arbitrary value
  localparam sfc_byte_t TY = 8'h21; // Arbitrary value
  localparam sfc_byte_t CP = 8'h0d; // Arbitrary value
  logic      mclk_in;
  logic      rst_in;
  logic      protect_n_in;
  logic      sel_n;
  logic      sclk;
  logic      mosi;
  logic      miso;
  logic      oe_n;
  logic      busy;
  logic      latch;
  int        n_mismatch;
  int        comparisons;
  int        cycles;
  int        hd;          // Header bytes of the last read
  sfc_byte_t s;
  sfc_top #(.CYCLE_NS(2000), .MAKER_CODE(MK), .TYPE_CODE(TY), .CAP_CODE(CP)) DUT (
    .mclk_in(mclk_in), .rst_in(rst_in), .sclk_in(sclk), .sel_n_in(sel_n),
    .serial_in_pin_in(mosi), .protect_n_in(protect_n_in),
    .serial_out_pin_out(miso), .serial_out_oe_n_out(oe_n),
    .busy_flag_out(busy), .write_latch_flag_out(latch));
  // Undriven output line reads as the inverse of the pin, so a late enable shows
  sfc_master_model m (.sel_n_out(sel_n), .sclk_out(sclk), .mosi_out(mosi),
    .miso_in(oe_n ? ~miso : miso));
  ////////////////////////////////////////////////////////////////////
  // 20 MHz system clock
  initial
  begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  // Hang guard; the full run needs about 7900 cycles
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input sfc_byte_t got, input sfc_byte_t exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Single-byte command, optionally with a broken bit count
  task automatic cmd(input sfc_byte_t op, input int nbits);
    m.tx = '{op};
    m.run(nbits);
  endtask
  task automatic stat(output sfc_byte_t st);
    m.tx = '{8'h05};
    m.run(24);
    st = m.rx[1];
  endtask
  // Poll until idle, bounded; a stuck busy shows as a mismatch
  task automatic wait_idle;
    sfc_byte_t st;
    for (int i = 0; i < 40; i++)
    begin
      stat(st);
      if (st[0] === 1'b0)
        return;
    end
    chk(st, 8'h00);
  endtask
  task automatic rd(input sfc_byte_t op, input sfc_addr_t a, input int n);
    m.tx = '{op, a[23:16], a[15:8], a[7:0]};
    if (op == 8'h0b)
      m.tx.push_back(8'h00);
    hd = m.tx.size();
    m.run(8 * (hd + n));
  endtask
  // Bytes past 256 get 40h added so the kept ones can be told apart
  task automatic wr(input sfc_addr_t a, input int n, input sfc_byte_t b, input int extra);
    m.tx = '{8'h0a, a[23:16], a[15:8], a[7:0]};
    for (int k = 0; k < n; k++)
      m.tx.push_back(8'(b + k + ((k > 255) ? 8'h40 : 8'h00)));
    m.run(8 * m.tx.size() + extra);
  endtask
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_in = 1'b1;
    protect_n_in = 1'b1;
    n_mismatch = 0;
    comparisons = 0;
    cycles = 0;
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    chk({5'h00, oe_n, latch, busy}, 8'h04);
    stat(s);
    chk(s, 8'h00);
    chk(m.rx[2], 8'h00);
    cmd(8'h06, 9);
    chk({7'h00, latch}, 8'h00);
    cmd(8'h06, 8);
    stat(s);
    chk(s, 8'h02);
    cmd(8'h04, 8);
    stat(s);
    chk(s, 8'h00);
    $display("test latch done");
    m.tx = '{8'h9f};
    m.run(8 * 21);
    for (int i = 0; i < 20; i++)
      chk(m.rx[i + 1], (i > 3) ? 8'h00 : (i == 0) ? MK :
          (i == 1) ? TY : (i == 2) ? CP : 8'h10);
    $display("test identify done");
    // Full page plus two: the last 256 land with offsets 0 and 1 on top
    cmd(8'h06, 8);
    wr(24'h010000, 258, 8'h00, 0);
    chk({7'h00, busy}, 8'h01);
    stat(s);
    chk(s, 8'h03);
    rd(8'h03, 24'h010002, 2);
    chk(m.rx[hd], 8'h00);
    wait_idle();
    chk({6'h00, latch, busy}, 8'h00);
    // Short rewrite across the page end; a second one mid-cycle is refused
    cmd(8'h06, 8);
    wr(24'h0100fe, 3, 8'hc0, 0);
    wr(24'h010000, 1, 8'h55, 0);
    m.tx = '{8'h9f};
    m.run(24);
    chk(m.rx[1], 8'h00);
    rd(8'h0b, 24'h010002, 1);
    chk(m.rx[hd], 8'h00);
    wait_idle();
    rd(8'h03, 24'h0100fd, 3);
    chk(m.rx[hd], 8'hfd);
    chk(m.rx[hd + 1], 8'hc0);
    chk(m.rx[hd + 2], 8'hc1);
    rd(8'h0b, 24'h010000, 3);
    chk(m.rx[hd], 8'hc2);
    chk(m.rx[hd + 1], 8'h41);
    chk(m.rx[hd + 2], 8'h02);
    rd(8'h03, 24'hffffff, 2);
    chk(m.rx[hd + 1], 8'hc2);
    $display("test rewrite done");
    // Refusals: protected page, broken byte, no latch
    cmd(8'h06, 8);
    @(posedge mclk_in) protect_n_in <= 1'b0;
    wr(24'h000010, 1, 8'h99, 0);
    chk({6'h00, latch, busy}, 8'h02);
    @(posedge mclk_in) protect_n_in <= 1'b1;
    wr(24'h010010, 1, 8'h99, 3);
    chk({6'h00, latch, busy}, 8'h02);
    cmd(8'h04, 8);
    wr(24'h010010, 1, 8'h99, 0);
    chk({6'h00, latch, busy}, 8'h00);
    rd(8'h03, 24'h010010, 1);
    chk(m.rx[hd], 8'h10);
    $display("test refusal done");
    test_done();
  end
endmodule
`default_nettype wire
